/* File: hdl/tbs_pkg.sv */
// Shared constants and types for the external time-base scaler.
// Assumes a 40 MHz core clock and a servo cycle derived from it.
package tbs_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int SERVO_FREQ_HZ = 2250;
  // Longest whole servo period in core cycles, rounded down
  localparam int SERVO_CYCLES = CLK_HZ / SERVO_FREQ_HZ;

  localparam int NUM_CH = 4;
  localparam int NUM_MOTORS = 2;
  localparam logic [1:0] VFC_CH = 2'h3;
  localparam int CNT_W = 24;
  localparam int FRAC_W = 5;
  localparam int IPOS_W = CNT_W + FRAC_W;
  localparam int TB_W = 24;
  localparam int POS_W = 32;
  localparam int TMR_W = 16;

  // Scale factor fixed point: 2^17 is the 100 percent point
  localparam int UNITY_SHIFT = 17;
  localparam logic [TB_W-1:0] TB_UNITY = 24'h020000;
  localparam logic [TB_W-1:0] TB_MAX = 24'h7fffff;
  localparam logic [TB_W-1:0] SLEW_MAX = 24'h7fffff;
  // Location of the scaled external entry
  localparam logic [15:0] TB_EXT_ADDR = 16'h0729;

  localparam logic [TB_W-1:0] RST_TB = 24'h000000;
  localparam logic [POS_W-1:0] RST_POS = 32'h00000000;
  localparam logic [TMR_W-1:0] TMR_MAX = 16'hffff;

  // Low two bits of a decode setting; bit 2 flips the counting sense
  typedef enum logic [1:0] {
    TBS_DEC_PULSE = 2'b00,
    TBS_DEC_X1 = 2'b01,
    TBS_DEC_X2 = 2'b10,
    TBS_DEC_X4 = 2'b11
  } tbs_dec_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [FRAC_W-1:0] frac;
  } tbs_ipos_t;

  typedef enum logic {
    TBS_PAUSE_IDLE = 1'b0,
    TBS_PAUSE_RUN = 1'b1
  } tbs_pause_t;

endpackage

/* File: hdl/tbs_decoder.sv */
// One encoder decoder-counter with period-timer sub-count interpolation.
// Assumes enc_a and enc_b are asynchronous pins; they are synchronised here.
`timescale 1ns/1ps
module tbs_decoder (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [2:0] decode_select,
  input wire logic interp_en,
  output tbs_pkg::tbs_ipos_t ipos
);

  logic [2:0] a_r, a_nxt, b_r, b_nxt;
  logic [tbs_pkg::CNT_W-1:0] count_r, count_nxt;
  logic [tbs_pkg::TMR_W-1:0] since_r, since_nxt, period_r, period_nxt;
  logic step, up, a_edge, b_edge;
  tbs_pkg::tbs_dec_mode_t mode;
  logic [tbs_pkg::TMR_W+4:0] quot;

  // Stage 0 feeds only stage 1; edges are seen between stages 1 and 2
  always_comb begin
    a_nxt = {a_r[1:0], enc_a};
    b_nxt = {b_r[1:0], enc_b};
    mode = tbs_pkg::tbs_dec_mode_t'(decode_select[1:0]);
    a_edge = a_r[1] ^ a_r[2];
    b_edge = b_r[1] ^ b_r[2];
    step = 1'b0;
    up = 1'b1;
    case (mode)
      tbs_pkg::TBS_DEC_PULSE: begin
        step = a_r[1] & ~a_r[2];
        up = b_r[1]; // Code 0 up with B high, code 4 up with B low
      end
      tbs_pkg::TBS_DEC_X1: begin
        step = a_r[1] & ~a_r[2];
        up = ~b_r[1];
      end
      tbs_pkg::TBS_DEC_X2: begin
        step = a_edge;
        up = a_r[1] ^ b_r[1];
      end
      tbs_pkg::TBS_DEC_X4: begin
        step = a_edge | b_edge;
        up = a_r[1] ^ b_r[2];
      end
      default: begin
        step = 1'b0;
        up = 1'b1;
      end
    endcase
    if (decode_select[2]) begin
      up = ~up;
    end
    count_nxt = count_r;
    if (step) begin
      count_nxt = up ? count_r + 24'h000001 : count_r - 24'h000001;
    end
    // Period timer: time since last count over last count period
    since_nxt = (since_r == tbs_pkg::TMR_MAX) ? since_r : since_r + 16'h0001;
    period_nxt = period_r;
    if (step) begin
      since_nxt = 16'h0000;
      period_nxt = (since_r == 16'h0000) ? 16'h0001 : since_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      a_r <= 3'h0;
      b_r <= 3'h0;
      count_r <= 24'h000000;
      since_r <= 16'h0000;
      period_r <= tbs_pkg::TMR_MAX;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      count_r <= count_nxt;
      since_r <= since_nxt;
      period_r <= period_nxt;
    end
  end

  // Fraction saturates below one count so position never runs ahead
  always_comb begin
    quot = {since_r, 5'h00} / {5'h00, period_r};
    ipos.count = count_r;
    ipos.frac = 5'h00;
    if (interp_en) begin
      ipos.frac = (quot > 21'h00001f) ? 5'h1f : quot[4:0];
    end
  end

endmodule

/* File: hdl/tbs_top.sv */
// External time-base scaler: counts a master frequency, scales it once per
// servo cycle and paces the commanded positions of one coordinate system.
// Assumes encoder pins and the converter pulse are asynchronous to core_clk.
// Assumes the configuration ports come from logic on core_clk and change rarely.
// Routing links are static straps but are synchronised like any other pin.
// Contract
// - Decode quadrature x4, x2, x1 or pulse-direction; bit 2 selects counting sense.
// - Converter pulses drive only the fourth counter when both links fitted.
// - Selected channel's count is sampled exactly once per servo cycle.
// - Period-timer interpolation is on by default for every counter.
// - Per cycle, position difference times scale factor forms time-base value.
// - Percent equals 100 times factor times counts per servo cycle over 131072.
// - Applied time-base value multiplies every commanded-position update.
// - Source pointer equal to 1833 selects the scaled external entry.
// - Any other pointer value selects the software time-base value.
// - All motors of the coordinate system follow the applied time base.
// - Per-cycle change of the applied value limited by slew limit.
// - Slew-limited external following loses sync; slip is never recovered.
// - Software-commanded values are also approached at the slew rate.
// - Fixed pause runs in real time; scaled pause follows time base.
// - Time-base arithmetic uses integers held in 24-bit registers.
// - Calculation saturates when input rate ratio reaches servo kHz.
`timescale 1ns/1ps
module tbs_top #(
  parameter int SERVO_CYCLES = tbs_pkg::SERVO_CYCLES,
  parameter int NUM_MOTORS = tbs_pkg::NUM_MOTORS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [tbs_pkg::NUM_CH-1:0] enc_a,
  input wire logic [tbs_pkg::NUM_CH-1:0] enc_b,
  input wire logic vfc_pulse,
  input wire logic vfc_route_link_a,
  input wire logic vfc_route_link_b,
  input wire logic [2:0] first_channel_decode_select,
  input wire logic [2:0] second_channel_decode_select,
  input wire logic [2:0] third_channel_decode_select,
  input wire logic [2:0] fourth_channel_decode_select,
  input wire logic [tbs_pkg::NUM_CH-1:0] interp_disable,
  input wire logic [1:0] tb_source_channel,
  input wire logic [tbs_pkg::TB_W-1:0] rate_scale_factor,
  input wire logic [15:0] time_base_source_pointer,
  input wire logic [tbs_pkg::TB_W-1:0] time_base_slew_limit,
  input wire logic [tbs_pkg::TB_W-1:0] sw_time_base,
  input wire logic [NUM_MOTORS-1:0][tbs_pkg::TB_W-1:0] cmd_step,
  input wire logic pause_start,
  input wire logic pause_scaled,
  input wire logic [tbs_pkg::POS_W-1:0] pause_length,
  output logic servo_tick_r,
  output logic [tbs_pkg::TB_W-1:0] ext_tb_value_r,
  output logic [tbs_pkg::TB_W-1:0] tb_applied_r,
  output logic tb_saturated_r,
  output logic slip_lost_r,
  output logic pause_busy_r,
  output logic [NUM_MOTORS-1:0][tbs_pkg::POS_W-1:0] cmd_pos_r
);

  localparam logic [31:0] TICK_LAST = 32'(SERVO_CYCLES - 1);

  tbs_pkg::tbs_ipos_t ipos [tbs_pkg::NUM_CH];
  logic [tbs_pkg::NUM_CH-1:0] ch_a, ch_b;
  logic [tbs_pkg::NUM_CH*3-1:0] dec_sel;
  logic [1:0] link_a_r, link_a_nxt, link_b_r, link_b_nxt;
  logic vfc_routed;

  // Routing links are pins too; two flops before the mux reads them
  always_comb begin
    link_a_nxt = {link_a_r[0], vfc_route_link_a};
    link_b_nxt = {link_b_r[0], vfc_route_link_b};
    // Only the second stage is read; the first may be metastable
    vfc_routed = link_a_r[1] & link_b_r[1];
  end

  // Synchroniser stages clear on reset so the pins own channel four
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link_a_r <= 2'h0;
      link_b_r <= 2'h0;
    end else begin
      link_a_r <= link_a_nxt;
      link_b_r <= link_b_nxt;
    end
  end

  // Channel routing: the converter has no other channel to go to
  always_comb begin
    ch_a = enc_a;
    ch_b = enc_b;
    // Converter has no direction line; B held low counts up with code 4
    if (vfc_routed) begin
      ch_a[tbs_pkg::VFC_CH] = vfc_pulse;
      ch_b[tbs_pkg::VFC_CH] = 1'b0;
    end
    // Channel c takes its three setting bits from slot c
    dec_sel = {fourth_channel_decode_select, third_channel_decode_select,
               second_channel_decode_select, first_channel_decode_select};
  end

  // One decoder-counter per input; interpolation on unless disabled
  for (genvar c = 0; c < tbs_pkg::NUM_CH; c++) begin : g_ch
    tbs_decoder u_dec (
      .core_clk(core_clk),
      .srst(srst),
      .enc_a(ch_a[c]),
      .enc_b(ch_b[c]),
      .decode_select(dec_sel[c*3 +: 3]),
      .interp_en(~interp_disable[c]),
      .ipos(ipos[c])
    );
  end

  // Servo-cycle divider; tick_d runs the update one cycle after sampling
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_nxt, tick_d_r;

  // Wrap at the last count gives exactly one tick per servo period
  always_comb begin
    tick_nxt = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick_nxt ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end

  // Counter restarts on reset, so the first tick lands a full period later
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_r <= 32'h00000000;
      servo_tick_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      servo_tick_r <= tick_nxt;
      tick_d_r <= servo_tick_r;
    end
  end

  // Time-base entry: difference of interpolated positions times factor
  tbs_pkg::tbs_ipos_t cur_pos, prev_r, prev_nxt;
  logic [tbs_pkg::IPOS_W-1:0] delta;
  logic [tbs_pkg::IPOS_W+tbs_pkg::TB_W-1:0] product;
  logic [tbs_pkg::IPOS_W+tbs_pkg::TB_W-1:0] scaled;
  logic [tbs_pkg::TB_W-1:0] ext_nxt;
  logic sat_nxt;

  always_comb begin
    cur_pos = ipos[tb_source_channel];
    prev_nxt = prev_r;
    ext_nxt = ext_tb_value_r;
    sat_nxt = tb_saturated_r;
    delta = cur_pos - prev_r;
    // A backward count would be a negative time base; treat it as zero
    if (delta[tbs_pkg::IPOS_W-1]) begin
      delta = '0;
    end
    product = {24'h000000, delta} * {29'h00000000, rate_scale_factor};
    // Drop the fraction bits: one count times the factor is the result
    scaled = product >> tbs_pkg::FRAC_W;
    // Sample once per servo cycle; the previous sample is replaced
    if (servo_tick_r) begin
      prev_nxt = cur_pos;
      sat_nxt = (scaled > {29'h00000000, tbs_pkg::TB_MAX});
      // Clamp instead of wrapping within the 24-bit register
      ext_nxt = sat_nxt ? tbs_pkg::TB_MAX : scaled[tbs_pkg::TB_W-1:0];
    end
  end

  // First sample after reset compares against zero; expect one odd cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_r <= '0;
      ext_tb_value_r <= tbs_pkg::RST_TB;
      tb_saturated_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      ext_tb_value_r <= ext_nxt;
      tb_saturated_r <= sat_nxt;
    end
  end

  // Source selection and slewing of the applied value
  logic use_ext;
  logic [tbs_pkg::TB_W-1:0] target, limit, applied_nxt;
  logic signed [tbs_pkg::TB_W:0] diff;
  logic restricted, slip_nxt;

  always_comb begin
    // Any pointer other than the external entry selects software
    use_ext = (time_base_source_pointer == tbs_pkg::TB_EXT_ADDR);
    target = use_ext ? ext_tb_value_r : sw_time_base;
    // Settings above the largest legal limit act as the largest
    limit = (time_base_slew_limit > tbs_pkg::SLEW_MAX) ? tbs_pkg::SLEW_MAX
          : time_base_slew_limit;
    // One extra bit keeps the signed difference exact
    diff = $signed({1'b0, target}) - $signed({1'b0, tb_applied_r});
    applied_nxt = tb_applied_r;
    restricted = 1'b0;
    slip_nxt = slip_lost_r;
    if (tick_d_r) begin
      applied_nxt = target;
      if (diff > $signed({1'b0, limit})) begin
        applied_nxt = tb_applied_r + limit;
        restricted = 1'b1;
      end else if (diff < -$signed({1'b0, limit})) begin
        applied_nxt = tb_applied_r - limit;
        restricted = 1'b1;
      end
      // Slip from a limited step is never made up later
      if (restricted && use_ext) begin
        slip_nxt = 1'b1;
      end
    end
  end

  // Applied value and sticky slip flag; only reset clears the flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tb_applied_r <= tbs_pkg::RST_TB;
      slip_lost_r <= 1'b0;
    end else begin
      tb_applied_r <= applied_nxt;
      slip_lost_r <= slip_nxt;
    end
  end

  // Commanded-position update of every motor, scaled by the time base
  for (genvar m = 0; m < NUM_MOTORS; m++) begin : g_motor
    logic signed [48:0] prod_m;
    logic [tbs_pkg::POS_W-1:0] pos_nxt;

    // Product holds the full signed range before the shift
    always_comb begin
      prod_m = $signed(cmd_step[m]) * $signed({1'b0, applied_nxt});
      pos_nxt = cmd_pos_r[m];
      if (tick_d_r) begin
        // Truncation trades a tiny residue per cycle for a short multiplier
        pos_nxt = cmd_pos_r[m] + 32'(prod_m >>> tbs_pkg::UNITY_SHIFT);
      end
    end

    // One register per motor position
    always_ff @(posedge core_clk) begin
      if (srst) begin
        cmd_pos_r[m] <= tbs_pkg::RST_POS;
      end else begin
        cmd_pos_r[m] <= pos_nxt;
      end
    end
  end

  // Pause timer: length in servo cycles times unity
  tbs_pkg::tbs_pause_t pause_st_r, pause_st_nxt;
  logic [tbs_pkg::POS_W-1:0] remain_r, remain_nxt, dec_amt;
  logic scaled_r, scaled_nxt;

  // A start while running is ignored; the running pause keeps its length
  always_comb begin
    pause_st_nxt = pause_st_r;
    remain_nxt = remain_r;
    scaled_nxt = scaled_r;
    dec_amt = scaled_r ? {8'h00, tb_applied_r} : {8'h00, tbs_pkg::TB_UNITY};
    case (pause_st_r)
      tbs_pkg::TBS_PAUSE_IDLE: begin
        if (pause_start) begin
          remain_nxt = pause_length;
          scaled_nxt = pause_scaled;
          pause_st_nxt = tbs_pkg::TBS_PAUSE_RUN;
        end
      end
      tbs_pkg::TBS_PAUSE_RUN: begin
        if (tick_d_r) begin
          // Last step may overshoot, so the remainder floors at zero
          if (remain_r <= dec_amt) begin
            remain_nxt = '0;
            pause_st_nxt = tbs_pkg::TBS_PAUSE_IDLE;
          end else begin
            remain_nxt = remain_r - dec_amt;
          end
        end
      end
      default: begin
        pause_st_nxt = tbs_pkg::TBS_PAUSE_IDLE;
      end
    endcase
  end

  // Busy mirrors the next state so it rises on the edge that takes the start
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pause_st_r <= tbs_pkg::TBS_PAUSE_IDLE;
      remain_r <= tbs_pkg::RST_POS;
      scaled_r <= 1'b0;
      pause_busy_r <= 1'b0;
    end else begin
      pause_st_r <= pause_st_nxt;
      remain_r <= remain_nxt;
      scaled_r <= scaled_nxt;
      pause_busy_r <= (pause_st_nxt == tbs_pkg::TBS_PAUSE_RUN);
    end
  end

endmodule

/* File: dv/tbs_top_assertions.sv */
// Port checker for the time-base scaler top level.
// Assumes a short servo period so that tick spacing fits a plain delay.
`timescale 1ns/1ps
module tbs_chk #(
  parameter int SERVO_CYCLES = 20,
  parameter int NUM_MOTORS = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] time_base_source_pointer,
  input wire logic [23:0] time_base_slew_limit,
  input wire logic [23:0] sw_time_base,
  input wire logic pause_start,
  input logic servo_tick_r,
  input logic [23:0] ext_tb_value_r,
  input logic [23:0] tb_applied_r,
  input logic tb_saturated_r,
  input logic slip_lost_r,
  input logic pause_busy_r,
  input logic [NUM_MOTORS-1:0][31:0] cmd_pos_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic ext_sel;
  logic sw_sel;
  // Full slew makes the applied value a pure copy of its source
  assign ext_sel = time_base_source_pointer == 16'h0729 && time_base_slew_limit == 24'h7fffff;
  assign sw_sel = time_base_source_pointer != 16'h0729 && time_base_slew_limit == 24'h7fffff;

  a_tick_period: assert property (servo_tick_r |-> ##SERVO_CYCLES servo_tick_r)
    else $error("servo tick spacing wrong");
  a_tick_single: assert property (servo_tick_r |=> !servo_tick_r [*8])
    else $error("servo tick longer than one cycle");
  a_ext_on_tick: assert property ($changed(ext_tb_value_r) |-> $past(servo_tick_r))
    else $error("external value moved off the servo cycle");
  a_ext_range: assert property (!ext_tb_value_r[23])
    else $error("external value beyond 24-bit positive range");
  a_sat_clamp: assert property (tb_saturated_r |-> ext_tb_value_r == 24'h7fffff)
    else $error("saturated value not clamped");
  a_slew_step: assert property ($changed(tb_applied_r) |->
    (tb_applied_r - $past(tb_applied_r) <= $past(time_base_slew_limit)) ||
    ($past(tb_applied_r) - tb_applied_r <= $past(time_base_slew_limit)))
    else $error("applied step above slew limit");
  a_ext_follow: assert property (servo_tick_r && ext_sel ##2 ext_sel |->
    tb_applied_r == ext_tb_value_r)
    else $error("applied value ignores external entry");
  a_sw_follow: assert property (servo_tick_r && sw_sel ##2 sw_sel && $stable(sw_time_base)
    |-> tb_applied_r == sw_time_base)
    else $error("applied value ignores software value");
  a_slip_sticky: assert property (slip_lost_r |=> slip_lost_r)
    else $error("slip flag cleared without reset");
  a_slip_ext: assert property ($rose(slip_lost_r) |->
    $past(time_base_source_pointer) == 16'h0729)
    else $error("slip flagged on software source");
  a_pause_take: assert property (pause_start && !pause_busy_r |=> pause_busy_r)
    else $error("pause not started");
  a_pos_moment: assert property ($changed(cmd_pos_r) |-> $past(servo_tick_r, 2))
    else $error("position moved off the update cycle");

  c_slip: cover property ($rose(slip_lost_r));
  c_sat: cover property ($rose(tb_saturated_r));
  c_pause: cover property ($fell(pause_busy_r));
endmodule
bind tbs_top tbs_chk #(.SERVO_CYCLES(SERVO_CYCLES), .NUM_MOTORS(NUM_MOTORS)) u_chk (
  .core_clk, .srst, .time_base_source_pointer, .time_base_slew_limit, .sw_time_base,
  .pause_start, .servo_tick_r, .ext_tb_value_r, .tb_applied_r, .tb_saturated_r,
  .slip_lost_r, .pause_busy_r, .cmd_pos_r);

/* File: dv/tbs_master.sv */
// Master frequency source: quadrature or pulse-and-direction lines.
// Assumes the bench sets mode and step period; lines hold when stopped.
`timescale 1ns/1ps
module tbs_master (
  input wire logic core_clk,
  input wire logic run,
  input wire logic fwd,
  input wire logic pulse,
  input wire logic [7:0] per,
  output logic a,
  output logic b
);
  logic [7:0] cnt_r = 8'h00;
  logic [1:0] ph_r = 2'h0;
  // Steps after the falling edge, like every other bench driver
  always @(negedge core_clk) begin
    if (run) begin
      cnt_r <= (cnt_r + 8'h01 >= per) ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r + 8'h01 >= per) begin
        ph_r <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
      end
    end
  end
  // Gray phases; a real encoder at rest keeps its levels
  assign a = pulse ? ph_r[0] : ph_r[1];
  assign b = pulse ? !fwd : ph_r[1] ^ ph_r[0];
endmodule

/* File: dv/tbs_top_bench.sv */
// Self-checking bench for the time-base scaler, servo period shortened.
// Assumes the master model and the bound port checker are compiled first.
`timescale 1ns/1ps
module tbs_top_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic m_a, m_b, vfc, tick, sat, slip, busy;
  logic lnk = 1'b0, run1 = 1'b0, fwd1 = 1'b1, pul1 = 1'b0, run2 = 1'b0;
  logic [2:0] dsel = 3'h3, dsel4 = 3'h4, xs;
  logic [3:0] idis = 4'hf;
  logic [1:0] src = 2'h1;
  logic [23:0] f = 24'h008000, slew = 24'h7fffff, sw = 24'h000000;
  logic [23:0] ext, app, v3, v7, a0;
  logic [15:0] ptr = 16'h0729;
  logic [1:0][23:0] step = {24'hffffc0, 24'h000100};
  logic p_go = 1'b0, p_sc = 1'b0;
  logic [31:0] p_len = 32'h0;
  logic [1:0][31:0] pos, p0;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  tbs_master m1 (.core_clk, .run(run1), .fwd(fwd1), .pulse(pul1), .per(8'h05),
    .a(m_a), .b(m_b));
  tbs_master m2 (.core_clk, .run(run2), .fwd(1'b1), .pulse(1'b1), .per(8'h0a),
    .a(vfc), .b());
  tbs_top #(.SERVO_CYCLES(20)) DUT (.core_clk, .srst, .enc_a({4{m_a}}), .enc_b({4{m_b}}),
    .vfc_pulse(vfc), .vfc_route_link_a(lnk), .vfc_route_link_b(lnk),
    .first_channel_decode_select(dsel), .second_channel_decode_select(dsel),
    .third_channel_decode_select(dsel), .fourth_channel_decode_select(dsel4),
    .interp_disable(idis), .tb_source_channel(src), .rate_scale_factor(f),
    .time_base_source_pointer(ptr), .time_base_slew_limit(slew), .sw_time_base(sw),
    .cmd_step(step), .pause_start(p_go), .pause_scaled(p_sc), .pause_length(p_len),
    .servo_tick_r(tick), .ext_tb_value_r(ext), .tb_applied_r(app), .tb_saturated_r(sat),
    .slip_lost_r(slip), .pause_busy_r(busy), .cmd_pos_r(pos));

  // 40 MHz core clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // Hang guard, well above the roughly 1100 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Tolerance only for the interpolated reading
  task automatic chk(input string nm, input logic [31:0] e, g, t);
    cmp_count++;
    if ($isunknown(g) || g + t < e || g > e + t) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Step past n servo updates, ending where applied values have landed
  task automatic sv(input int n);
    repeat (n) begin
      @(negedge core_clk);
      while (tick !== 1'b1) @(negedge core_clk);
      repeat (2) @(negedge core_clk);
    end
  endtask

  // Four edges per window of 20 clocks; sense decides which code counts up
  task automatic t_decode();
    run1 = 1'b1;
    sv(3);
    v3 = ext;
    dsel = 3'h7;
    sv(3);
    v7 = ext;
    chk("x4 sum", 32'h20000, v3 + v7, 0);
    chk("x4 one sense", 0, (v3 != 0) && (v7 != 0), 0);
    xs = (v3 != 0) ? 3'h3 : 3'h7;
    dsel = xs - 3'h1;
    sv(3);
    chk("x2", 32'h10000, ext, 0);
    dsel = xs - 3'h2;
    sv(3);
    chk("x1", 32'h8000, ext, 0);
    pul1 = 1'b1;
    dsel = 3'h4;
    sv(3);
    chk("pulse up", 32'h10000, ext, 0);
    dsel = 3'h0;
    sv(3);
    chk("pulse down", 0, ext, 0);
  endtask

  // Links steal the fourth counter from its pins
  task automatic t_vfc();
    src = 2'h3;
    dsel4 = 3'h4;
    sv(3);
    chk("ch4 pins", 32'h10000, ext, 0);
    lnk = 1'b1;
    run2 = 1'b1;
    sv(3);
    chk("ch4 converter", 32'h8000, ext, 0);
    lnk = 1'b0;
    src = 2'h1;
    pul1 = 1'b0;
    dsel = xs;
    idis = 4'h0;
    sv(3);
    chk("interpolated", 32'h20000, ext, 32'h4000);
    idis = 4'hf;
  endtask

  task automatic t_sat();
    f = 24'h7fffff;
    sv(2);
    chk("clamped", 32'h7fffff, ext, 0);
    chk("sat set", 1, sat, 0);
    f = 24'h008000;
    sv(2);
    chk("sat clear", 0, sat, 0);
    chk("ext applied", 32'h20000, app, 0);
  endtask

  task automatic t_motor(input logic [23:0] s, input logic [31:0] e0, e1);
    ptr = 16'h0728;
    sw = s;
    sv(2);
    p0 = pos;
    sv(1);
    chk("sw applied", s, app, 0);
    chk("motor0 step", e0, pos[0] - p0[0], 0);
    chk("motor1 step", e1, pos[1] - p0[1], 0);
  endtask

  // Second start mid-pause with a short length must be ignored
  task automatic t_pause(input logic s, input int e);
    int n;
    n = 0;
    p_sc = s;
    p_len = 32'h00060000;
    p_go = 1'b1;
    @(negedge core_clk);
    p_go = 1'b0;
    p_len = 32'h00020000;
    chk("busy", 1, busy, 0);
    for (int k = 0; k < 400 && busy === 1'b1; k++) begin
      p_go = (k == 2);
      if (tick === 1'b1) n++;
      @(negedge core_clk);
    end
    chk(s ? "scaled ticks" : "fixed ticks", e, n, 0);
  endtask

  task automatic t_slew();
    slew = 24'h000800;
    sw = 24'h018000;
    sv(1);
    a0 = app;
    sv(1);
    chk("sw slew", 32'h800, app - a0, 0);
    chk("no sw slip", 0, slip, 0);
    ptr = 16'h0729;
    sv(1);
    a0 = app;
    sv(1);
    chk("ext slew", 32'h800, app - a0, 0);
    chk("slip", 1, slip, 0);
    slew = 24'h7fffff;
    sv(2);
    chk("slip kept", 1, slip, 0);
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    chk("applied after reset", 0, app, 0);
    t_decode();
    t_vfc();
    t_sat();
    t_motor(24'h020000, 32'h100, 32'hffffffc0);
    t_motor(24'h010000, 32'h80, 32'hffffffe0);
    t_pause(1'b0, 3);
    t_pause(1'b1, 6);
    t_slew();
    complete_run();
  end
endmodule
